/* File: rtl/gpc_port.sv */
/*
 * Two 8-pin general-purpose ports with pin-change flag and mask logic,
 * reached over an AHB-Lite slave.
 * Assumes pins sampled on mclk, single word transfers, one slave on the bus.
 */
// The AHB-Lite interface to the registers was left to the implementer.
module gpc_port (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Pins
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe,
   output logic [15:0] pin_pullup,
   // Interrupt requests and acknowledges
   input wire logic [1:0] irq_ack,
   output logic [1:0] irq_req
);
   localparam int NP = gpc_pkg::NPORT;
   localparam int NB = gpc_pkg::NPIN;

   logic [NP-1:0][NB-1:0] out_r, out_nxt, dir_r, dir_nxt, dir_q_r, dir_q_nxt;
   logic [NP-1:0][NB-1:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt, prev_r, prev_nxt;
   logic [NP-1:0][NB-1:0] mask_r, mask_nxt, chg;
   logic [NP-1:0] pudp_r, pudp_nxt, bbm_r, bbm_nxt;
   logic [1:0] gen_r, gen_nxt, flag_r, flag_nxt, irq_r, irq_nxt, grp_set;
   logic gpud_r, gpud_nxt, gie_r, gie_nxt;
   logic [NP-1:0][NB-1:0] oe_r, oe_nxt, pout_r, pout_nxt, pu_r, pu_nxt;
   logic hready_r, hready_nxt, hresp_r;
   logic [31:0] hrdata_r, hrdata_nxt;
   gpc_pkg::gpc_dph_s dph_r, dph_nxt;
   logic wr_en, rd_pend_r, rd_pend_nxt;
   logic [gpc_pkg::IDXW-1:0] rd_idx_r, rd_idx_nxt;
   logic [31:0] rdata;
   logic [NB-1:0] wbyte;

   // Bus decode: address phase capture, write in data phase, reads one wait state.
   always_comb begin
      dph_nxt.valid = hsel && hready && (htrans == gpc_pkg::HTRANS_NONSEQ);
      dph_nxt.write = hwrite;
      dph_nxt.idx = haddr[gpc_pkg::ADDR_LSB +: gpc_pkg::IDXW];
      rd_pend_nxt = dph_nxt.valid && !hwrite;
      rd_idx_nxt = dph_nxt.idx;
      hready_nxt = !rd_pend_nxt;
      wr_en = dph_r.valid && dph_r.write;
      wbyte = hwdata[NB-1:0];
   end

   // Read multiplexer.
   always_comb begin
      rdata = gpc_pkg::RST_WORD;
      unique case (rd_idx_r)
         gpc_pkg::IDX_IN_A: rdata[NB-1:0] = sync2_r[0];
         gpc_pkg::IDX_DIR_A: rdata[NB-1:0] = dir_r[0];
         gpc_pkg::IDX_OUT_A: rdata[NB-1:0] = out_r[0];
         gpc_pkg::IDX_IN_B: rdata[NB-1:0] = sync2_r[1];
         gpc_pkg::IDX_DIR_B: rdata[NB-1:0] = dir_r[1];
         gpc_pkg::IDX_OUT_B: rdata[NB-1:0] = out_r[1];
         gpc_pkg::IDX_PORT_CTRL: begin
            rdata[gpc_pkg::PCR_BBM_LSB +: NP] = bbm_r;
            rdata[gpc_pkg::PCR_PUD_LSB +: NP] = pudp_r;
         end
         gpc_pkg::IDX_CHG_FLAGS: rdata[1:0] = flag_r;
         gpc_pkg::IDX_CPU_CTRL: rdata[gpc_pkg::CPU_PUD_BIT] = gpud_r;
         gpc_pkg::IDX_GRP_CTRL: begin
            rdata[gpc_pkg::GRP_EN_LSB +: 2] = gen_r;
            rdata[gpc_pkg::GRP_GIE_BIT] = gie_r;
         end
         gpc_pkg::IDX_MASK_LOW: rdata[NB-1:0] = mask_r[gpc_pkg::GRP_LOW];
         gpc_pkg::IDX_MASK_HIGH: rdata[NB-1:0] = mask_r[gpc_pkg::GRP_HIGH];
         default: rdata = gpc_pkg::RST_WORD;
      endcase
      hrdata_nxt = rd_pend_r ? rdata : hrdata_r;
   end

   // Port registers, synchroniser and pin drive, one generate per port.
   for (genvar p = 0; p < NP; p++) begin : g_port
      localparam logic [gpc_pkg::IDXW-1:0] I_IN = p ? gpc_pkg::IDX_IN_B : gpc_pkg::IDX_IN_A;
      localparam logic [gpc_pkg::IDXW-1:0] I_DIR = p ? gpc_pkg::IDX_DIR_B : gpc_pkg::IDX_DIR_A;
      localparam logic [gpc_pkg::IDXW-1:0] I_OUT = p ? gpc_pkg::IDX_OUT_B : gpc_pkg::IDX_OUT_A;
      always_comb begin
         out_nxt[p] = out_r[p];
         dir_nxt[p] = dir_r[p];
         if (wr_en && dph_r.idx == I_OUT) begin
            out_nxt[p] = wbyte;
         end
         if (wr_en && dph_r.idx == I_IN) begin
            out_nxt[p] = out_r[p] ^ wbyte;
         end
         if (wr_en && dph_r.idx == I_DIR) begin
            dir_nxt[p] = wbyte;
         end
         dir_q_nxt[p] = dir_r[p];
         sync1_nxt[p] = pin_in[p*NB +: NB];
         sync2_nxt[p] = sync1_r[p];
         prev_nxt[p] = sync2_r[p];
         chg[p] = sync2_r[p] ^ prev_r[p];
         // Direction one drives; with the port's bbm bit set, a fresh input-to-output switch waits a cycle.
         oe_nxt[p] = dir_r[p] & ~({NB{bbm_r[p]}} & ~dir_q_r[p]);
         pout_nxt[p] = out_r[p];
         pu_nxt[p] = ~dir_r[p] & out_r[p] & ~{NB{gpud_r | pudp_r[p]}};
      end
   end

   // Control, mask and flag registers.
   always_comb begin
      bbm_nxt = bbm_r;
      pudp_nxt = pudp_r;
      gpud_nxt = gpud_r;
      gen_nxt = gen_r;
      gie_nxt = gie_r;
      mask_nxt = mask_r;
      if (wr_en) begin
         unique case (dph_r.idx)
            gpc_pkg::IDX_PORT_CTRL: begin
               bbm_nxt = hwdata[gpc_pkg::PCR_BBM_LSB +: NP];
               pudp_nxt = hwdata[gpc_pkg::PCR_PUD_LSB +: NP];
            end
            gpc_pkg::IDX_CPU_CTRL: gpud_nxt = hwdata[gpc_pkg::CPU_PUD_BIT];
            gpc_pkg::IDX_GRP_CTRL: begin
               gen_nxt = hwdata[gpc_pkg::GRP_EN_LSB +: 2];
               gie_nxt = hwdata[gpc_pkg::GRP_GIE_BIT];
            end
            gpc_pkg::IDX_MASK_LOW: mask_nxt[gpc_pkg::GRP_LOW] = wbyte;
            gpc_pkg::IDX_MASK_HIGH: mask_nxt[gpc_pkg::GRP_HIGH] = wbyte;
            default: ;
         endcase
      end
      grp_set[gpc_pkg::GRP_HIGH] = gen_r[gpc_pkg::GRP_HIGH]
         && |(chg[1] & mask_r[gpc_pkg::GRP_HIGH]);
      grp_set[gpc_pkg::GRP_LOW] = gen_r[gpc_pkg::GRP_LOW]
         && |(chg[0] & mask_r[gpc_pkg::GRP_LOW]);
      flag_nxt = flag_r & ~irq_ack;
      if (wr_en && dph_r.idx == gpc_pkg::IDX_CHG_FLAGS) begin
         flag_nxt = flag_nxt & ~hwdata[1:0];
      end
      flag_nxt = flag_nxt | grp_set;
      irq_nxt = flag_r & gen_r & {2{gie_r}};
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         out_r <= '0;
         dir_r <= '0;
         dir_q_r <= '0;
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
         mask_r <= '0;
         pudp_r <= gpc_pkg::RST_PAIR;
         bbm_r <= gpc_pkg::RST_PAIR;
         gpud_r <= 1'b0;
         gen_r <= gpc_pkg::RST_PAIR;
         gie_r <= 1'b0;
         flag_r <= gpc_pkg::RST_PAIR;
         irq_r <= gpc_pkg::RST_PAIR;
         pout_r <= '0;
         pu_r <= '0;
         hready_r <= 1'b1;
         hresp_r <= gpc_pkg::HRESP_OKAY;
         hrdata_r <= gpc_pkg::RST_WORD;
         dph_r <= '0;
         rd_pend_r <= 1'b0;
         rd_idx_r <= '0;
      end else begin
         out_r <= out_nxt;
         dir_r <= dir_nxt;
         dir_q_r <= dir_q_nxt;
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r <= prev_nxt;
         mask_r <= mask_nxt;
         pudp_r <= pudp_nxt;
         bbm_r <= bbm_nxt;
         gpud_r <= gpud_nxt;
         gen_r <= gen_nxt;
         gie_r <= gie_nxt;
         flag_r <= flag_nxt;
         irq_r <= irq_nxt;
         pout_r <= pout_nxt;
         pu_r <= pu_nxt;
         hready_r <= hready_nxt;
         hresp_r <= gpc_pkg::HRESP_OKAY;
         hrdata_r <= hrdata_nxt;
         dph_r <= dph_nxt;
         rd_pend_r <= rd_pend_nxt;
         rd_idx_r <= rd_idx_nxt;
      end
   end

   // Output enables clear without a clock so pins float during reset.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         oe_r <= '0;
      end else begin
         oe_r <= oe_nxt;
      end
   end

   assign hreadyout = hready_r;
   assign hresp = hresp_r;
   assign hrdata = hrdata_r;
   assign pin_out = pout_r;
   assign pin_oe = oe_r;
   assign pin_pullup = pu_r;
   assign irq_req = irq_r;

   // Checks.
   property p_upper_set;
      @(posedge mclk) disable iff (!rst_n)
      grp_set[1] |=> flag_r[1];
   endproperty
   a_upper_set: assert property (p_upper_set) else $error("upper flag not set");

   property p_lower_set;
      @(posedge mclk) disable iff (!rst_n)
      (gen_r[0] && (chg[0] & mask_r[0]) != '0) |=> flag_r[0];
   endproperty
   a_lower_set: assert property (p_lower_set) else $error("lower flag not set");

   property p_req;
      @(posedge mclk) disable iff (!rst_n)
      (flag_r[1] && gie_r && gen_r[1]) |=> irq_req[1];
   endproperty
   a_req: assert property (p_req) else $error("request missing");

   property p_ack_clear;
      @(posedge mclk) disable iff (!rst_n)
      (irq_ack[0] && !grp_set[0]) |=> !flag_r[0];
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared");

   property p_flag_rsvd;
      @(posedge mclk) disable iff (!rst_n)
      (rd_pend_r && rd_idx_r == gpc_pkg::IDX_CHG_FLAGS) |=> hrdata[7:2] == '0;
   endproperty
   a_flag_rsvd: assert property (p_flag_rsvd) else $error("reserved flag bits set");

   property p_upper_gate;
      @(posedge mclk) disable iff (!rst_n)
      (!flag_r[1] && (!gen_r[1] || mask_r[1] == '0)) |=> !flag_r[1];
   endproperty
   a_upper_gate: assert property (p_upper_gate) else $error("masked change set flag");

   property p_toggle;
      @(posedge mclk) disable iff (!rst_n)
      (wr_en && dph_r.idx == gpc_pkg::IDX_IN_A) |=> out_r[0] == ($past(out_r[0]) ^ $past(wbyte));
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle write wrong");

   property p_pud;
      @(posedge mclk) disable iff (!rst_n)
      gpud_r |=> pin_pullup == '0;
   endproperty
   a_pud: assert property (p_pud) else $error("pull-up despite disable");

   sequence s_turn_on;
      bbm_r[0] && (dir_r[0] & ~dir_q_r[0]) != '0;
   endsequence
   property p_bbm;
      @(posedge mclk) disable iff (!rst_n)
      s_turn_on |=> (oe_r[0] & $past(dir_r[0] & ~dir_q_r[0])) == '0;
   endproperty
   a_bbm: assert property (p_bbm) else $error("no tri-state gap");

   property p_off_fast;
      @(posedge mclk) disable iff (!rst_n)
      (~dir_r[1] & dir_q_r[1]) != '0 |=> (oe_r[1] & $past(~dir_r[1] & dir_q_r[1])) == '0;
   endproperty
   a_off_fast: assert property (p_off_fast) else $error("slow turn-off");

   property p_reset_float;
      @(posedge mclk) !rst_n |-> pin_oe == '0;
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("pin driven in reset");

   property p_sync;
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n, 2) |-> sync2_r == $past(pin_in, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("sample delay wrong");

   property p_lower_gate;
      @(posedge mclk) disable iff (!rst_n)
      (!flag_r[0] && (!gen_r[0] || mask_r[0] == '0)) |=> !flag_r[0];
   endproperty
   a_lower_gate: assert property (p_lower_gate) else $error("masked lower change set flag");

   property p_lower_req;
      @(posedge mclk) disable iff (!rst_n)
      (flag_r[0] && gie_r && gen_r[0]) |=> irq_req[0];
   endproperty
   a_lower_req: assert property (p_lower_req) else $error("lower request missing");

   property p_gie_off;
      @(posedge mclk) disable iff (!rst_n)
      !gie_r |=> irq_req == '0;
   endproperty
   a_gie_off: assert property (p_gie_off) else $error("request without global enable");

   property p_write_clear;
      @(posedge mclk) disable iff (!rst_n)
      (wr_en && dph_r.idx == gpc_pkg::IDX_CHG_FLAGS && hwdata[1] && !grp_set[1])
         |=> !flag_r[1];
   endproperty
   a_write_clear: assert property (p_write_clear) else $error("written one kept flag");

   property p_flag_hold;
      @(posedge mclk) disable iff (!rst_n)
      (flag_r[0] && !irq_ack[0]
         && !(wr_en && dph_r.idx == gpc_pkg::IDX_CHG_FLAGS && hwdata[0]))
         |=> flag_r[0];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

   property p_dir_input;
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> (pin_oe & ~$past(dir_r)) == '0;
   endproperty
   a_dir_input: assert property (p_dir_input) else $error("input pin driven");

   property p_out_follow;
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> pin_out == $past(out_r);
   endproperty
   a_out_follow: assert property (p_out_follow) else $error("pin level not data bit");

   property p_pullup_off;
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> (pin_pullup & ($past(dir_r) | ~$past(out_r))) == '0;
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pull-up on wrong pin");

   property p_no_bbm;
      @(posedge mclk) disable iff (!rst_n)
      !bbm_r[1] |=> oe_r[1] == $past(dir_r[1]);
   endproperty
   a_no_bbm: assert property (p_no_bbm) else $error("gap without port enable");

   sequence s_gap;
      bbm_r[0] && dir_r[0][0] && !dir_q_r[0][0];
   endsequence
   property p_bbm_on;
      @(posedge mclk) disable iff (!rst_n)
      s_gap ##1 dir_r[0][0] |=> oe_r[0][0];
   endproperty
   a_bbm_on: assert property (p_bbm_on) else $error("output not enabled after gap");

   property p_prev;
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> prev_r == $past(sync2_r);
   endproperty
   a_prev: assert property (p_prev) else $error("previous sample wrong");
endmodule // gpc_port

/* File: common/gpc_pkg.sv */
/*
 * Package for the general-purpose port block: register indices, field
 * positions, reset values and the bus carrier struct.
 * Assumes an AHB-Lite master with 32-bit data and word-aligned accesses.
 */
package gpc_pkg;
   localparam int NPORT = 2;
   localparam int NPIN = 8;
   localparam int IDXW = 8;
   // Register indices; byte address is four times the index.
   localparam logic [IDXW-1:0] IDX_IN_A = 8'h03;
   localparam logic [IDXW-1:0] IDX_DIR_A = 8'h04;
   localparam logic [IDXW-1:0] IDX_OUT_A = 8'h05;
   localparam logic [IDXW-1:0] IDX_IN_B = 8'h06;
   localparam logic [IDXW-1:0] IDX_DIR_B = 8'h07;
   localparam logic [IDXW-1:0] IDX_OUT_B = 8'h08;
   localparam logic [IDXW-1:0] IDX_PORT_CTRL = 8'h12;
   localparam logic [IDXW-1:0] IDX_CHG_FLAGS = 8'h1B;
   localparam logic [IDXW-1:0] IDX_CPU_CTRL = 8'h35;
   localparam logic [IDXW-1:0] IDX_GRP_CTRL = 8'h68;
   localparam logic [IDXW-1:0] IDX_MASK_LOW = 8'h6B;
   localparam logic [IDXW-1:0] IDX_MASK_HIGH = 8'h6C;
   // Field positions.
   localparam int PCR_BBM_LSB = 0;
   localparam int PCR_PUD_LSB = 4;
   localparam int CPU_PUD_BIT = 4;
   localparam int GRP_EN_LSB = 0;
   localparam int GRP_GIE_BIT = 7;
   localparam int GRP_LOW = 0;
   localparam int GRP_HIGH = 1;
   localparam int ADDR_LSB = 2;
   // Reset values and AHB encodings.
   localparam logic [NPIN-1:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_PAIR = 2'h0;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

   // Captured address phase of an AHB transfer.
   typedef struct packed {
      logic valid;
      logic write;
      logic [IDXW-1:0] idx;
   } gpc_dph_s;
endpackage

/* File: verification/gpc_pins.sv */
/*
 * Board model of the sixteen port pins.
 * Assumes the board drives a pin only where ext_en is high.
 */
module gpc_pins (
   // Clock
   input wire logic mclk,
   // Device side
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] pin_pullup,
   // Board drivers
   input wire logic [15:0] ext_en,
   input wire logic [15:0] ext_val,
   // Pin levels
   output logic [15:0] pin_in
);
   logic [15:0] last_r;
   logic [15:0] drv;
   // A floating pin shows the inverse of its last driven level.
   always_comb begin
      drv = pin_oe | ext_en | pin_pullup;
      for (int i = 0; i < 16; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
            pin_pullup[i] ? 1'b1 : ~last_r[i];
      end
   end
   always_ff @(posedge mclk) begin
      last_r <= (pin_in & drv) | (last_r & ~drv);
   end
endmodule // gpc_pins

/* File: verification/gpc_port_bench.sv */
/*
 * Self-checking bench for the port block.
 * Assumes one AHB-Lite slave with hready tied to hreadyout.
 */
module gpc_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, irq_ack, irq_req;
   logic [2:0] hsize;
   logic [15:0] pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val;
   int fails, n_tests;
   gpc_port gpc_port_i (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .irq_ack(irq_ack), .irq_req(irq_req));
   gpc_pins gpc_pins_i (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One single transfer; each takes at least two edges, so direction writes stay spaced.
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      haddr <= {22'h0, idx, 2'h0};
      htrans <= gpc_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge mclk);
      while (hreadyout !== 1'b1) begin
         @(posedge mclk);
      end
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge mclk);
      while (hreadyout !== 1'b1) begin
         @(posedge mclk);
      end
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, {31'h0, gpc_pkg::HRESP_OKAY});
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(nm, rd, {24'h0, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic flip(input logic [15:0] m);
      ext_val <= ext_val ^ m;
      cyc(8);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge mclk);
      fails++;
      end_of_test;
   end
   initial begin
      rst_n <= 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      irq_ack = 2'h0;
      ext_en = 16'hFFFF;
      ext_val = 16'h3C00;
      n_tests = 0;
      fails = 0;
      cyc(4);
      chk("oe_in_reset", {16'h0, pin_oe}, 32'h0);
      cyc(4);
      rst_n <= 1'b1;
      rdc("mask_low", gpc_pkg::IDX_MASK_LOW, 8'h00);
      rdc("mask_high", gpc_pkg::IDX_MASK_HIGH, 8'h00);
      rdc("flags", gpc_pkg::IDX_CHG_FLAGS, 8'h00);
      rdc("unmapped", 8'h00, 8'h00);
      wr(gpc_pkg::IDX_MASK_LOW, 8'hA5);
      wr(gpc_pkg::IDX_MASK_HIGH, 8'h5A);
      rdc("mask_low", gpc_pkg::IDX_MASK_LOW, 8'hA5);
      rdc("mask_high", gpc_pkg::IDX_MASK_HIGH, 8'h5A);
      $display("test registers done");
      wr(gpc_pkg::IDX_OUT_A, 8'h5A);
      wr(gpc_pkg::IDX_DIR_A, 8'h0F);
      cyc(2);
      chk("oe", {24'h0, pin_oe[7:0]}, 32'h0F);
      chk("out", {24'h0, pin_out[7:0] & pin_oe[7:0]}, 32'h0A);
      chk("pullup", {24'h0, pin_pullup[7:0]}, 32'h50);
      wr(gpc_pkg::IDX_CPU_CTRL, 8'h10);
      cyc(2);
      chk("pullup_gpud", {16'h0, pin_pullup}, 32'h0);
      wr(gpc_pkg::IDX_CPU_CTRL, 8'h00);
      wr(gpc_pkg::IDX_OUT_B, 8'hFF);
      wr(gpc_pkg::IDX_PORT_CTRL, 8'h10);
      cyc(2);
      chk("pullup_ppud", {16'h0, pin_pullup}, 32'hFF00);
      wr(gpc_pkg::IDX_PORT_CTRL, 8'h00);
      wr(gpc_pkg::IDX_IN_A, 8'h81);
      rdc("toggle", gpc_pkg::IDX_OUT_A, 8'hDB);
      rdc("dir_kept", gpc_pkg::IDX_DIR_A, 8'h0F);
      rdc("in_a", gpc_pkg::IDX_IN_A, 8'h0B);
      rdc("in_b", gpc_pkg::IDX_IN_B, 8'h3C);
      $display("test port done");
      wr(gpc_pkg::IDX_DIR_A, 8'h00);
      wr(gpc_pkg::IDX_PORT_CTRL, 8'h01);
      wr(gpc_pkg::IDX_DIR_A, 8'h01);
      cyc(2);
      chk("bbm_gap", {31'h0, pin_oe[0]}, 32'h0);
      cyc(1);
      chk("bbm_on", {31'h0, pin_oe[0]}, 32'h1);
      wr(gpc_pkg::IDX_DIR_B, 8'h01);
      cyc(2);
      chk("no_bbm_b", {31'h0, pin_oe[8]}, 32'h1);
      wr(gpc_pkg::IDX_DIR_A, 8'h00);
      cyc(2);
      chk("to_input", {31'h0, pin_oe[0]}, 32'h0);
      wr(gpc_pkg::IDX_DIR_B, 8'h00);
      $display("test break before make done");
      wr(gpc_pkg::IDX_MASK_LOW, 8'h01);
      wr(gpc_pkg::IDX_MASK_HIGH, 8'h80);
      wr(gpc_pkg::IDX_GRP_CTRL, 8'h83);
      flip(16'h0002);
      rdc("masked_pin", gpc_pkg::IDX_CHG_FLAGS, 8'h00);
      flip(16'h0001);
      rdc("low_flag", gpc_pkg::IDX_CHG_FLAGS, 8'h01);
      chk("irq_low", {30'h0, irq_req}, 32'h1);
      wr(gpc_pkg::IDX_CHG_FLAGS, 8'h02);
      rdc("zero_write", gpc_pkg::IDX_CHG_FLAGS, 8'h01);
      wr(gpc_pkg::IDX_CHG_FLAGS, 8'h01);
      rdc("one_clear", gpc_pkg::IDX_CHG_FLAGS, 8'h00);
      flip(16'h8000);
      rdc("high_flag", gpc_pkg::IDX_CHG_FLAGS, 8'h02);
      chk("irq_high", {30'h0, irq_req}, 32'h2);
      irq_ack <= 2'h2;
      cyc(1);
      irq_ack <= 2'h0;
      cyc(2);
      rdc("ack_clear", gpc_pkg::IDX_CHG_FLAGS, 8'h00);
      wr(gpc_pkg::IDX_GRP_CTRL, 8'h81);
      flip(16'h8000);
      rdc("grp_off", gpc_pkg::IDX_CHG_FLAGS, 8'h00);
      wr(gpc_pkg::IDX_GRP_CTRL, 8'h01);
      flip(16'h0001);
      rdc("gie_off_flag", gpc_pkg::IDX_CHG_FLAGS, 8'h01);
      chk("gie_off_irq", {30'h0, irq_req}, 32'h0);
      $display("test change flags done");
      wr(gpc_pkg::IDX_DIR_A, 8'h0F);
      cyc(3);
      chk("oe_before_reset", {16'h0, pin_oe}, 32'h0F);
      rst_n <= 1'b0;
      #1;
      chk("oe_async", {16'h0, pin_oe}, 32'h0);
      cyc(3);
      rst_n <= 1'b1;
      rdc("dir_reset", gpc_pkg::IDX_DIR_A, 8'h00);
      rdc("flags_reset", gpc_pkg::IDX_CHG_FLAGS, 8'h00);
      $display("test mid reset done");
      end_of_test;
   end
endmodule // gpc_port_bench
